//--- rtl/dcoc_top.sv
// Dual comparator output control: registers, sync, edge flags and output routing
`timescale 1ns/10ps

module dcoc_top #(
   parameter int INSTR_DIV = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] analog_raw,
   input wire logic tmr_clk_prescaled,
   input wire logic tmr_src_is_sysclk,
   input wire logic sleep_mode,
   input wire logic [1:0] shutdown_source_enable,
   input wire logic [1:0] conversion_trigger_select,
   input wire logic [1:0] timer_external_reset_select,
   input wire logic [1:0] compare_irq_enable,
   output dcoc_pkg::dcoc_analog_s [1:0] analog_ctrl,
   output dcoc_pkg::dcoc_route_s [1:0] route,
   output logic [1:0] compare_irq_flag,
   output logic wake_req
);

   initial begin
      if (INSTR_DIV < 1 || INSTR_DIV > 255) begin
         $error("INSTR_DIV out of range");
      end
      // The result bit is read-only, so the write mask must leave it out
      if (dcoc_pkg::CTRL0_WMASK[dcoc_pkg::B_RESULT]) begin
         $error("Result bit is writable in the control zero mask");
      end
   end

   // APB decode; word-aligned, index is byte address over four
   logic [11:0] idx;
   logic acc;
   logic wr;
   logic hit;
   assign idx = {2'b00, paddr[11:2]} | {paddr[13:12], 10'h000};
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pready = 1'b1;
   // Unmapped addresses answer with an error; a write still lands if only paddr[1:0] or paddr[15:14] is off
   assign hit = (idx >= dcoc_pkg::IDX_CMP2_CTRL0) && (idx <= dcoc_pkg::IDX_FLAGS) && (paddr[1:0] == 2'b00)
      && (paddr[15:14] == 2'b00);
   assign pslverr = acc && !hit;

   // Instruction cycle enable, one pulse every INSTR_DIV clocks
   logic [7:0] div_q;
   logic icyc;
   assign icyc = (div_q == 8'(INSTR_DIV - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
      end else begin
         div_q <= icyc ? 8'h00 : div_q + 8'h01;
      end
   end

   // Timer clock arrives from outside: three flops, the last two feeding the falling edge detect
   logic tclk_s1_q;
   logic tclk_s2_q;
   logic tclk_s3_q;
   logic tclk_fall;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tclk_s1_q <= 1'b0;
         tclk_s2_q <= 1'b0;
         tclk_s3_q <= 1'b0;
      end else begin
         tclk_s1_q <= tmr_clk_prescaled;
         tclk_s2_q <= tclk_s1_q;
         tclk_s3_q <= tclk_s2_q;
      end
   end
   // sleep gating of sync
   // A system-derived timer clock halts in sleep, so the synced path freezes
   assign tclk_fall = tclk_s3_q && !tclk_s2_q && !(sleep_mode && tmr_src_is_sysclk);

   // Raw analog results are asynchronous: two-flop sync, shared by both channels
   logic [1:0] raw_s1_q;
   logic [1:0] raw_s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_s1_q <= 2'b00;
         raw_s2_q <= 2'b00;
      end else begin
         raw_s1_q <= analog_raw;
         raw_s2_q <= raw_s1_q;
      end
   end

   logic [7:0] ctrl0_q [2];
   logic [1:0] ctrl1_q [2];
   logic [2:0] nsel_q [2];
   logic [2:0] psel_q [2];
   logic [1:0] result_q;
   logic [1:0] flag_q;
   logic [1:0] pin_q;
   logic [1:0] rise_pulse;
   logic [11:0] base [2];
   logic [7:0] rd_ch [2];
   assign base[0] = dcoc_pkg::IDX_CMP1_CTRL0;
   assign base[1] = dcoc_pkg::IDX_CMP2_CTRL0;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_cmp
         logic en;
         logic inv;
         logic level;
         logic rise;
         logic fall;
         logic set_ev;
         logic clr;
         logic wr_c0;
         logic wr_c1;
         logic wr_n;
         logic wr_p;
         logic synced;
         logic sel_c0;
         logic sel_c1;
         logic sel_n;
         logic sel_p;
         logic [7:0] rd_c0;
         // Slot select within this comparator's set, shared by write and read
         assign sel_c0 = (idx == base[g]);
         assign sel_c1 = (idx == base[g] + dcoc_pkg::OFS_CTRL1);
         assign sel_n = (idx == base[g] + dcoc_pkg::OFS_NSEL);
         assign sel_p = (idx == base[g] + dcoc_pkg::OFS_PSEL);
         assign wr_c0 = wr && sel_c0;
         assign wr_c1 = wr && sel_c1;
         assign wr_n = wr && sel_n;
         assign wr_p = wr && sel_p;
         assign en = ctrl0_q[g][dcoc_pkg::B_ENABLE];
         assign inv = ctrl0_q[g][dcoc_pkg::B_INVERT];
         // disabled comparator reads low before inversion, so toggles make edges
         assign level = (en & raw_s2_q[g]) ^ inv;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl0_q[g] <= dcoc_pkg::CTRL0_RST;
               ctrl1_q[g] <= dcoc_pkg::CTRL1_RST[1:0];
               nsel_q[g] <= dcoc_pkg::SEL_RST;
               psel_q[g] <= dcoc_pkg::SEL_RST;
            end else begin
               if (wr_c0) begin
                  ctrl0_q[g] <= pwdata[7:0] & dcoc_pkg::CTRL0_WMASK;
               end
               if (wr_c1) begin
                  ctrl1_q[g] <= pwdata[1:0];
               end
               if (wr_n) begin
                  nsel_q[g] <= pwdata[2:0];
               end
               if (wr_p) begin
                  psel_q[g] <= pwdata[2:0];
               end
            end
         end

         assign rise = icyc && level && !result_q[g];
         assign fall = icyc && !level && result_q[g];
         assign set_ev = (rise && ctrl1_q[g][dcoc_pkg::B_RISE]) || (fall && ctrl1_q[g][dcoc_pkg::B_FALL]);
         assign clr = wr && (idx == dcoc_pkg::IDX_FLAGS) && pwdata[g];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               result_q[g] <= 1'b0;
               flag_q[g] <= 1'b0;
            end else begin
               if (icyc) begin
                  result_q[g] <= level;
               end
               flag_q[g] <= set_ev | (flag_q[g] & !clr);
            end
         end

         // sync mode latches on timer clock falling edge
         assign synced = ctrl0_q[g][dcoc_pkg::B_SYNC];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_q[g] <= 1'b0;
            end else if (!synced || tclk_fall) begin
               pin_q[g] <= level;
            end
         end
         assign rise_pulse[g] = rise;

         // Read-back of this set; zero when not selected so sets can be OR-ed
         assign rd_c0 = ctrl0_q[g] | (8'(result_q[g]) << dcoc_pkg::B_RESULT);
         assign rd_ch[g] = sel_c0 ? rd_c0
            : sel_c1 ? {6'h00, ctrl1_q[g]}
            : sel_n ? {5'h00, nsel_q[g]}
            : sel_p ? {5'h00, psel_q[g]}
            : 8'h00;

         assign analog_ctrl[g].nmux.ext[0] = en && (nsel_q[g] == dcoc_pkg::NSEL_IN0);
         assign analog_ctrl[g].nmux.ext[1] = en && (nsel_q[g] == dcoc_pkg::NSEL_IN0 + 3'h1);
         assign analog_ctrl[g].nmux.ext[2] = en && (nsel_q[g] == dcoc_pkg::NSEL_IN3 - 3'h1);
         assign analog_ctrl[g].nmux.ext[3] = en && (nsel_q[g] == dcoc_pkg::NSEL_IN3);
         assign analog_ctrl[g].nmux.fref = en && (nsel_q[g] == dcoc_pkg::NSEL_FREF);
         assign analog_ctrl[g].nmux.gnd = en && (nsel_q[g] == dcoc_pkg::NSEL_GND);
         assign analog_ctrl[g].pmux.ext[0] = en && (psel_q[g] == dcoc_pkg::PSEL_IN0);
         assign analog_ctrl[g].pmux.ext[1] = en && (psel_q[g] == dcoc_pkg::PSEL_IN1);
         assign analog_ctrl[g].pmux.dac = en && (psel_q[g] == dcoc_pkg::PSEL_DAC);
         assign analog_ctrl[g].pmux.fref = en && (psel_q[g] == dcoc_pkg::PSEL_FREF);
         assign analog_ctrl[g].pmux.gnd = en && (psel_q[g] == dcoc_pkg::PSEL_GND);
         assign analog_ctrl[g].enable = en;
         assign analog_ctrl[g].hysteresis_enable = en && ctrl0_q[g][dcoc_pkg::B_HYST];

         assign route[g].shutdown_req = pin_q[g] && shutdown_source_enable[g];
         assign route[g].adc_trigger = rise_pulse[g] && conversion_trigger_select[g];
         assign route[g].timer_reset = pin_q[g] && timer_external_reset_select[g];
         assign route[g].pin_out = pin_q[g];
      end
   endgenerate

   assign compare_irq_flag = flag_q;
   assign wake_req = sleep_mode && |(flag_q & compare_irq_enable);

   // Read mux; the two sets and the shared registers never overlap in index
   logic [7:0] rd8;
   logic [7:0] rd_shared;
   assign rd_shared = (idx == dcoc_pkg::IDX_MIRROR) ? {6'h00, result_q}
      : (idx == dcoc_pkg::IDX_FLAGS) ? {6'h00, flag_q}
      : 8'h00;
   assign rd8 = rd_ch[0] | rd_ch[1] | rd_shared;
   assign prdata = (acc && hit && !pwrite) ? {24'h00_0000, rd8} : dcoc_pkg::RDATA_ZERO;

endmodule

//--- rtl/dcoc_pkg.sv
// Package: register map, field positions and carriers for the dual comparator control block
package dcoc_pkg;

   // Register indices (printed offsets); byte address is index times four
   localparam logic [11:0] IDX_CMP2_CTRL0 = 12'hf35;
   localparam logic [11:0] IDX_CMP2_CTRL1 = 12'hf36;
   localparam logic [11:0] IDX_CMP2_NSEL = 12'hf37;
   localparam logic [11:0] IDX_CMP2_PSEL = 12'hf38;
   localparam logic [11:0] IDX_CMP1_CTRL0 = 12'hf39;
   localparam logic [11:0] IDX_CMP1_CTRL1 = 12'hf3a;
   localparam logic [11:0] IDX_CMP1_NSEL = 12'hf3b;
   localparam logic [11:0] IDX_CMP1_PSEL = 12'hf3c;
   localparam logic [11:0] IDX_MIRROR = 12'hf3d;
   // Flag register of our own: bit0 comparator one flag, bit1 comparator two flag; write 1 clears
   localparam logic [11:0] IDX_FLAGS = 12'hf3e;
   // Slot offsets inside one comparator's set of four
   localparam logic [11:0] OFS_CTRL1 = 12'h001;
   localparam logic [11:0] OFS_NSEL = 12'h002;
   localparam logic [11:0] OFS_PSEL = 12'h003;
   // Writable control zero bits: enable, polarity, hysteresis, sync
   localparam logic [7:0] CTRL0_WMASK = 8'h93;

   // Control zero field positions
   localparam int B_ENABLE = 7;
   localparam int B_RESULT = 6;
   localparam int B_INVERT = 4;
   localparam int B_HYST = 1;
   localparam int B_SYNC = 0;
   // Control one field positions
   localparam int B_RISE = 1;
   localparam int B_FALL = 0;
   localparam int SEL_W = 3;

   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [2:0] SEL_RST = 3'h0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Negative input codes
   localparam logic [2:0] NSEL_IN0 = 3'h0;
   localparam logic [2:0] NSEL_IN3 = 3'h3;
   localparam logic [2:0] NSEL_FREF = 3'h6;
   localparam logic [2:0] NSEL_GND = 3'h7;
   // Positive input codes
   localparam logic [2:0] PSEL_IN0 = 3'h0;
   localparam logic [2:0] PSEL_IN1 = 3'h1;
   localparam logic [2:0] PSEL_DAC = 3'h5;
   localparam logic [2:0] PSEL_FREF = 3'h6;
   localparam logic [2:0] PSEL_GND = 3'h7;

   // One-hot analog switch controls for one comparator
   typedef struct packed {
      logic [3:0] ext;
      logic fref;
      logic gnd;
   } dcoc_nmux_s;

   typedef struct packed {
      logic [1:0] ext;
      logic dac;
      logic fref;
      logic gnd;
   } dcoc_pmux_s;

   // Per comparator analog controls
   typedef struct packed {
      logic enable;
      logic hysteresis_enable;
      dcoc_nmux_s nmux;
      dcoc_pmux_s pmux;
   } dcoc_analog_s;

   // Per comparator routed outputs
   typedef struct packed {
      logic shutdown_req;
      logic adc_trigger;
      logic timer_reset;
      logic pin_out;
   } dcoc_route_s;

endpackage

//--- test/dcoc_far_model.sv
// Far-side model: prescaled timer clock source and conversion trigger counter
`timescale 1ns/10ps
module dcoc_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire dcoc_pkg::dcoc_route_s [1:0] route,
   output logic tclk_q,
   output logic [7:0] adc_q
);
   logic [1:0] div_q;
   // timer clock source; held low when stopped so no stray edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 2'h0;
         tclk_q <= 1'b0;
      end else if (run) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) tclk_q <= ~tclk_q;
      end else begin
         tclk_q <= 1'b0;
      end
   end
   // one conversion started per cycle with a trigger pulse from either comparator; two pulses in one cycle count once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) adc_q <= 8'h00;
      else if (route[0].adc_trigger | route[1].adc_trigger) adc_q <= adc_q + 8'h01;
   end
endmodule

//--- test/dcoc_checker_assertions.sv
// Checker: port-level properties of the comparator control block
`timescale 1ns/10ps
module dcoc_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic sleep_mode,
   input wire logic [1:0] shutdown_source_enable,
   input wire logic [1:0] conversion_trigger_select,
   input wire logic [1:0] timer_external_reset_select,
   input wire logic [1:0] compare_irq_enable,
   input wire dcoc_pkg::dcoc_analog_s [1:0] analog_ctrl,
   input wire dcoc_pkg::dcoc_route_s [1:0] route,
   input wire logic [1:0] compare_irq_flag,
   input wire logic wake_req
);
   // Access decode, mirrors the slave's own map
   wire acc = psel & penable;
   wire [13:0] idx = paddr[15:2];
   wire mapped = (paddr[1:0] == 2'h0) && (idx >= 14'hf35) && (idx <= 14'hf3e);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_shutdown_route: assert property (route[0].shutdown_req == (route[0].pin_out & shutdown_source_enable[0]))
      else $error("shutdown request mismatch");
   a_adc_pulse: assert property (route[0].adc_trigger |-> conversion_trigger_select[0] ##1 !route[0].adc_trigger)
      else $error("conversion trigger wrong");
   a_timer_reset: assert property (route[1].timer_reset == (route[1].pin_out & timer_external_reset_select[1]))
      else $error("timer reset mismatch");
   a_wake_request: assert property (wake_req == (sleep_mode & |(compare_irq_flag & compare_irq_enable)))
      else $error("wake request mismatch");
   a_off_quiet: assert property (!analog_ctrl[0].enable |-> analog_ctrl[0] == '0)
      else $error("disabled comparator drives controls");
   a_neg_onehot: assert property ($onehot0(analog_ctrl[0].nmux))
      else $error("negative switches not one-hot");
   a_pos_onehot: assert property ($onehot0(analog_ctrl[0].pmux))
      else $error("positive switches not one-hot");
   a_flag_cleared: assert property ($fell(compare_irq_flag[0]) |-> $past(acc & pwrite & (idx == 14'hf3e)))
      else $error("flag fell without clearing write");
   a_unmapped_err: assert property (acc & !mapped |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_mapped_narrow: assert property (acc & mapped |-> !pslverr && prdata[31:8] == 24'h00_0000)
      else $error("mapped read wider than a byte");
   c_flag_rise: cover property ($rose(compare_irq_flag[0]));
   c_adc_pulse: cover property (route[0].adc_trigger);
   c_wake: cover property (wake_req);
endmodule
bind dcoc_top dcoc_checker dcoc_checker_inst (.*);

//--- test/tb.sv
// Testbench: registers, decode, edge flags, routing and sync of the comparator block
`timescale 1ns/10ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, tsrc, sleep, wake, tclk;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] raw, sse, cts, ters, cie, flag;
   logic [7:0] adc_n;
   dcoc_pkg::dcoc_analog_s [1:0] actl;
   dcoc_pkg::dcoc_route_s [1:0] route;
   int mismatches, tests_run;
   dcoc_top #(.INSTR_DIV(4)) dcoc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analog_raw(raw), .tmr_clk_prescaled(tclk), .tmr_src_is_sysclk(tsrc), .sleep_mode(sleep),
      .shutdown_source_enable(sse), .conversion_trigger_select(cts), .timer_external_reset_select(ters),
      .compare_irq_enable(cie), .analog_ctrl(actl), .route(route), .compare_irq_flag(flag), .wake_req(wake));
   dcoc_far_model dcoc_far_model_inst (.pclk(pclk), .presetn(presetn), .run(run), .route(route),
      .tclk_q(tclk), .adc_q(adc_n));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // One APB transfer, request held until pready is sampled high; only the watchdog ends a wait
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
         output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] x, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x, what);
   endtask
   // Fixed waits cover the sync flops plus one instruction cycle
   task automatic step(input logic [1:0] v, input int n);
      @(posedge pclk);
      raw <= v;
      repeat (n) @(posedge pclk);
   endtask
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 9; i++) begin
         if (i != 2 && i != 6) rd(16'h3cd4 + 16'(4 * i), 32'h0000_0000, "reset value");
      end
      wr(16'h3cf4, 32'h0000_00ff);
      rd(16'h3cf4, 32'h0000_0000, "mirror write");
      apb(1'b0, 16'h3cfc, 32'h0000_0000, r, e);
      chk(32'(e), 32'h1, "unmapped error");
      $display("test reset done");
   endtask
   task automatic t_decode();
      logic [2:0] c;
      wr(16'h3ce4, 32'h0000_0080);
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(16'h3cec, {24'h00_0000, 5'h1f, c});
         wr(16'h3cf0, {24'h00_0000, 5'h1f, c});
         rd(16'h3cec, 32'(c), "select readback");
         chk(32'(actl[0].nmux), (i < 4) ? 32'h4 << c : (i > 5) ? 32'(8 - i) : 32'h0, "neg decode");
         chk(32'(actl[0].pmux), (i < 2) ? 32'h8 << c : (i > 4) ? 32'h1 << (7 - i) : 32'h0, "pos decode");
      end
      $display("test decode done");
   endtask
   task automatic t_edges();
      logic [7:0] n0;
      n0 = adc_n;
      wr(16'h3ce8, 32'h0000_0002);
      step(2'b01, 12);
      chk(32'(flag[0]), 32'h1, "rise flag");
      chk(32'(adc_n - n0), 32'h1, "conversion start");
      chk(32'(route[0].shutdown_req), 32'h1, "shutdown");
      rd(16'h3cf4, 32'h0000_0001, "mirror one");
      wr(16'h3cf8, 32'h0000_0001);
      step(2'b00, 12);
      chk(32'(flag[0]), 32'h0, "fall ignored");
      wr(16'h3ce8, 32'h0000_0001);
      step(2'b01, 12);
      chk(32'(flag[0]), 32'h0, "rise ignored");
      step(2'b00, 12);
      chk(32'(flag[0]), 32'h1, "fall flag");
      sleep <= 1'b1;
      cie <= 2'b01;
      step(2'b00, 1);
      chk(32'(wake), 32'h1, "wake");
      sleep <= 1'b0;
      cie <= 2'b00;
      $display("test edges done");
   endtask
   task automatic t_polarity();
      wr(16'h3ce4, 32'h0000_0002);
      wr(16'h3ce8, 32'h0000_0002);
      wr(16'h3cf8, 32'h0000_0001);
      wr(16'h3ce4, 32'h0000_0012);
      step(2'b00, 12);
      chk(32'(flag[0]), 32'h1, "polarity edge");
      rd(16'h3ce4, 32'h0000_0052, "result inverted");
      $display("test polarity done");
   endtask
   task automatic t_sync();
      wr(16'h3ce8, 32'h0000_0000);
      wr(16'h3ce4, 32'h0000_0080);
      wr(16'h3ce4, 32'h0000_0081);
      step(2'b01, 20);
      chk(32'(route[0].pin_out), 32'h0, "sync held");
      run <= 1'b1;
      step(2'b01, 20);
      chk(32'(route[0].pin_out), 32'h1, "sync update");
      tsrc <= 1'b1;
      sleep <= 1'b1;
      step(2'b00, 30);
      chk(32'(route[0].pin_out), 32'h1, "sleep frozen");
      sleep <= 1'b0;
      step(2'b00, 20);
      chk(32'(route[0].pin_out), 32'h0, "sleep left");
      $display("test sync done");
   endtask
   // Second comparator set: hysteresis, rise flag, mirror bit 1, routing, clearing both flags
   task automatic t_second();
      logic [7:0] n0;
      n0 = adc_n;
      wr(16'h3cd4, 32'h0000_0082);
      wr(16'h3cd8, 32'h0000_0002);
      chk(32'(actl[1].hysteresis_enable), 32'h1, "second hysteresis");
      step(2'b10, 12);
      chk(32'(flag[1]), 32'h1, "second rise flag");
      chk(32'(route[1].timer_reset), 32'h1, "timer reset");
      chk(32'(route[1].shutdown_req), 32'h0, "shutdown not enabled");
      chk(32'(adc_n - n0), 32'h0, "trigger not selected");
      rd(16'h3cf4, 32'h0000_0002, "mirror two");
      rd(16'h3cd4, 32'h0000_00c2, "second result");
      rd(16'h3cf8, 32'h0000_0003, "both flags");
      wr(16'h3cf8, 32'h0000_0003);
      rd(16'h3cf8, 32'h0000_0000, "flags cleared");
      $display("test second done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      {mismatches, tests_run} = 0;
      {presetn, psel, penable, pwrite, run, tsrc, sleep, paddr, pwdata, raw, cie} = 0;
      {sse, cts, ters} = 6'b01_01_11;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_decode();
      t_edges();
      t_polarity();
      t_sync();
      t_second();
      report_and_stop();
   end
   // Watchdog well beyond the expected run of a few hundred cycles
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
endmodule
